//--- inc/csc_defs.svh
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH
// ==========================================================
// Register offsets
`define CSC_ADDR_CTRL      4'h0
`define CSC_ADDR_STATUS    4'h1
`define CSC_ADDR_CAL       4'h2
`define CSC_ADDR_FUSE      4'h3
// ==========================================================
// Control register fields
`define CSC_CTRL_MODE_LSB  0
`define CSC_CTRL_MODE_MSB  1
`define CSC_CTRL_SLEEP_BIT 2
// ==========================================================
// Reset values: shipped fuse setting and calibration
`define CSC_SHIP_SOURCE    4'h1
`define CSC_SHIP_STARTUP   2'h2
`define CSC_SHIP_AMP       1'h1
`define CSC_CAL_RESET      8'h00
// ==========================================================
// Start-up counts in ticks of the selected source
`define CSC_CNT_6          17'h00006
`define CSC_CNT_18         17'h00012
`define CSC_CNT_258        17'h00102
`define CSC_CNT_1K         17'h00400
`define CSC_CNT_16K        17'h04000
`define CSC_CNT_32K        17'h08000
// Reset time-outs in watchdog oscillator ticks
`define CSC_SHORT_TIMEOUT  17'h01000
`define CSC_LONG_TIMEOUT   17'h10000
`endif

//--- inc/csc_pkg.sv
package csc_pkg;

   // ==========================================================
   // Clock source kinds
   typedef enum logic [2:0] {
      SRC_EXT_CLOCK = 3'h0,
      SRC_INT_RC    = 3'h1,
      SRC_EXT_RC    = 3'h2,
      SRC_LF_XTAL   = 3'h3,
      SRC_XTAL      = 3'h4
   } csc_source_e;

   // Additional delay after a reset
   typedef enum logic [1:0] {
      DLY_NONE  = 2'h0,
      DLY_SHORT = 2'h1,
      DLY_LONG  = 2'h2
   } csc_delay_e;

   // Sleep modes
   typedef enum logic [1:0] {
      SLP_IDLE   = 2'h0,
      SLP_ADC_NR = 2'h1,
      SLP_PDOWN  = 2'h2,
      SLP_PSAVE  = 2'h3
   } csc_sleep_e;

   // Controller states
   typedef enum logic [5:0] {
      ST_RESET     = 6'h01,
      ST_OSC_START = 6'h02,
      ST_RST_DELAY = 6'h04,
      ST_RUN       = 6'h08,
      ST_SLEEP     = 6'h10,
      ST_WAKE      = 6'h20
   } csc_state_e;

   // ==========================================================
   // Configuration bits, one means unprogrammed
   typedef struct packed {
      logic       oscillator_amp_option;
      logic [1:0] startup_time_select;
      logic [3:0] clock_source_select;
   } csc_fuse_s;

   // Decoded configuration
   typedef struct packed {
      csc_source_e kind;
      logic [2:0]  xtal_range;
      logic [3:0]  rc_mhz;
      logic [16:0] startup_ticks;
      csc_delay_e  delay;
   } csc_decode_s;

   // Clock domain enables
   typedef struct packed {
      logic core;
      logic periph;
      logic flash;
      logic asy;
      logic conv;
   } csc_clk_en_s;

endpackage : csc_pkg

//--- design/csc_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser with a rising-edge pulse on the settled side
module csc_sync
   import csc_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q,
   output logic      [WIDTH-1:0] rise
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] last;
      logic [WIDTH-1:0] rise;
   } csc_sync_s;

   csc_sync_s st;
   csc_sync_s next_st;

   // ==========================================================
   // Next state: first stage feeds only the second stage
   always_comb
   begin
      next_st      = st;
      next_st.meta = d;
      next_st.sync = st.meta;
      next_st.last = st.sync;
      next_st.rise = st.sync & ~st.last;
   end

   // Register the state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         st.last <= '0;
         st.rise <= '0;
         st.meta <= next_st.meta;
         st.sync <= next_st.sync;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign q    = st.sync;
   assign rise = st.rise;

endmodule : csc_sync

//--- design/csc_decode.sv
`timescale 1ns/1ns
`include "csc_defs.svh"
// Decodes sampled configuration bits into source, ranges and counts
module csc_decode
   import csc_pkg::*;
#(
   parameter logic [16:0] CNT_16K = `CSC_CNT_16K,
   parameter logic [16:0] CNT_32K = `CSC_CNT_32K
)
(
   input  wire csc_fuse_s   fuse,
   output csc_decode_s      dec
);

   logic [2:0] sut3;

   // ==========================================================
   // Source, range and count decode
   always_comb
   begin
      sut3              = {fuse.clock_source_select[0], fuse.startup_time_select};
      dec               = '0;
      dec.kind          = SRC_EXT_CLOCK;
      dec.delay         = (fuse.startup_time_select == 2'h0) ? DLY_NONE :
                          (fuse.startup_time_select == 2'h1) ? DLY_SHORT : DLY_LONG;
      dec.startup_ticks = `CSC_CNT_6;
      if (fuse.clock_source_select >= 4'hA)
      begin
         dec.kind = SRC_XTAL;
         // Amplifier option zero means programmed: one wide range
         if (!fuse.oscillator_amp_option)
            dec.xtal_range = 3'h4;
         else
            dec.xtal_range = fuse.clock_source_select[3:1] - 3'h4;
         case (sut3)
            3'h0, 3'h1:      dec.startup_ticks = `CSC_CNT_258;
            3'h2, 3'h3, 3'h4: dec.startup_ticks = `CSC_CNT_1K;
            default:         dec.startup_ticks = CNT_16K;
         endcase
         case (sut3)
            3'h0, 3'h3, 3'h6: dec.delay = DLY_SHORT;
            3'h1, 3'h4, 3'h7: dec.delay = DLY_LONG;
            default:          dec.delay = DLY_NONE;
         endcase
      end
      else if (fuse.clock_source_select == 4'h9)
      begin
         dec.kind          = SRC_LF_XTAL;
         dec.startup_ticks = fuse.startup_time_select[1] ? CNT_32K : `CSC_CNT_1K;
         dec.delay         = (fuse.startup_time_select == 2'h0) ? DLY_SHORT : DLY_LONG;
      end
      else if (fuse.clock_source_select >= 4'h5)
      begin
         dec.kind          = SRC_EXT_RC;
         dec.startup_ticks = (fuse.startup_time_select == 2'h3) ? `CSC_CNT_6 : `CSC_CNT_18;
         dec.delay         = (fuse.startup_time_select == 2'h0) ? DLY_NONE :
                             (fuse.startup_time_select == 2'h2) ? DLY_LONG : DLY_SHORT;
      end
      else if (fuse.clock_source_select != 4'h0)
      begin
         dec.kind   = SRC_INT_RC;
         dec.rc_mhz = 4'h1 << (fuse.clock_source_select[2:0] - 3'h1);
      end
   end

endmodule : csc_decode

//--- design/csc_clock_control.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "csc_defs.svh"
module csc_clock_control
   import csc_pkg::*;
#(
   parameter logic [16:0] SHORT_TIMEOUT_CYCLES = `CSC_SHORT_TIMEOUT,
   parameter logic [16:0] LONG_TIMEOUT_CYCLES  = `CSC_LONG_TIMEOUT,
   parameter logic [16:0] CNT_16K              = `CSC_CNT_16K,
   parameter logic [16:0] CNT_32K              = `CSC_CNT_32K
)
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [3:0]  clock_source_select,
   input  wire logic [1:0]  startup_time_select,
   input  wire logic        oscillator_amp_option,
   input  wire logic [7:0]  factory_calibration,
   input  wire logic        source_tick,
   input  wire logic        watchdog_tick,
   input  wire logic        wake_event,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [15:0] rdata,
   output logic             core_clock_en,
   output logic             peripheral_clock_en,
   output logic             program_memory_clock_en,
   output logic             async_timer_clock_en,
   output logic             converter_clock_en,
   output logic             async_detect_en,
   output logic [7:0]       rc_calibration_register,
   output logic             core_running
);

   // ==========================================================
   // State
   typedef struct packed {
      csc_state_e  state;
      csc_sleep_e  mode;
      csc_fuse_s   fuse;
      logic [16:0] count;
      logic [7:0]  cal;
      csc_clk_en_s en;
      logic        detect;
      logic [15:0] rdata;
   } csc_ctl_s;

   csc_ctl_s    st;
   csc_ctl_s    next_st;
   csc_decode_s dec;
   logic [14:0] cfg_q;
   logic [2:0]  tick_q;
   logic [2:0]  tick_rise;
   logic        src_tick;
   logic        wdt_tick;
   logic        wake;
   logic [16:0] delay_ticks;
   logic        start_done;
   logic        delay_done;

   // ==========================================================
   // Pin synchronisers
   csc_sync #(
      .WIDTH (15)
   ) u_cfg_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .d       ({oscillator_amp_option, startup_time_select, clock_source_select, factory_calibration}),
      .q       (cfg_q),
      .rise    ()
   );

   csc_sync #(
      .WIDTH (3)
   ) u_tick_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .d       ({wake_event, watchdog_tick, source_tick}),
      .q       (tick_q),
      .rise    (tick_rise)
   );

   assign src_tick = tick_rise[0];
   assign wdt_tick = tick_rise[1];
   assign wake     = tick_rise[2];

   // Decode of the held configuration
   csc_decode #(
      .CNT_16K (CNT_16K),
      .CNT_32K (CNT_32K)
   ) u_decode (
      .fuse (st.fuse),
      .dec  (dec)
   );

   // ==========================================================
   // Count targets and completion terms
   always_comb
   begin
      case (dec.delay)
         DLY_SHORT: delay_ticks = SHORT_TIMEOUT_CYCLES;
         DLY_LONG:  delay_ticks = LONG_TIMEOUT_CYCLES;
         default:   delay_ticks = 17'h00000;
      endcase
      start_done = src_tick && (st.count == dec.startup_ticks - 17'h00001);
      delay_done = wdt_tick && (st.count == delay_ticks - 17'h00001);
   end

   // ==========================================================
   // Next-state logic: sequencer, gating and register port
   always_comb
   begin
      next_st       = st;
      next_st.rdata = 16'h0000;
      case (st.state)
         ST_RESET:
         begin
            // Sample configuration and calibration once after release
            next_st.fuse  = cfg_q[14:8];
            next_st.cal   = cfg_q[7:0];
            next_st.count = 17'h00000;
            next_st.state = ST_OSC_START;
         end
         ST_OSC_START:
         begin
            if (start_done)
            begin
               next_st.count = 17'h00000;
               next_st.state = (dec.delay == DLY_NONE) ? ST_RUN : ST_RST_DELAY;
            end
            else if (src_tick)
               next_st.count = st.count + 17'h00001;
         end
         ST_RST_DELAY:
         begin
            if (delay_done)
               next_st.state = ST_RUN;
            else if (wdt_tick)
               next_st.count = st.count + 17'h00001;
         end
         ST_RUN:
         begin
            if (wr_stb && addr == `CSC_ADDR_CTRL && wdata[`CSC_CTRL_SLEEP_BIT])
               next_st.state = ST_SLEEP;
         end
         ST_SLEEP:
         begin
            next_st.count = 17'h00000;
            if (wake)
               next_st.state = (st.mode == SLP_PDOWN || st.mode == SLP_PSAVE) ? ST_WAKE : ST_RUN;
         end
         ST_WAKE:
         begin
            if (start_done)
               next_st.state = ST_RUN;
            else if (src_tick)
               next_st.count = st.count + 17'h00001;
         end
         default:
            next_st.state = ST_RESET;
      endcase

      // Mode and calibration writes
      if (wr_stb && addr == `CSC_ADDR_CTRL)
         next_st.mode = csc_sleep_e'(wdata[`CSC_CTRL_MODE_MSB:`CSC_CTRL_MODE_LSB]);
      if (wr_stb && addr == `CSC_ADDR_CAL)
         next_st.cal = wdata[7:0];

      // Clock enables for the next state and the next mode
      // A mode written beside the sleep bit gates from the first sleep cycle
      next_st.en = '0;
      case (next_st.state)
         ST_RUN:
            next_st.en = 5'h1F;
         ST_SLEEP:
         begin
            // Core and program memory stop in every sleep mode
            next_st.en.core   = 1'b0;
            next_st.en.periph = (next_st.mode == SLP_IDLE);
            next_st.en.conv   = (next_st.mode == SLP_IDLE) || (next_st.mode == SLP_ADC_NR);
            next_st.en.asy    = (next_st.mode != SLP_PDOWN);
         end
         ST_OSC_START, ST_RST_DELAY, ST_WAKE:
            next_st.en.asy = (next_st.mode != SLP_PDOWN);
         default:
            next_st.en = '0;
      endcase
      next_st.en.flash = next_st.en.core;
      next_st.detect   = (next_st.state != ST_RESET) && !next_st.en.periph;

      // Read data stands in the cycle after the strobe
      if (rd_stb)
      begin
         case (addr)
            `CSC_ADDR_CTRL:   next_st.rdata = {14'h0000, st.mode};
            `CSC_ADDR_STATUS: next_st.rdata = {st.state, dec.kind, dec.xtal_range, dec.rc_mhz};
            `CSC_ADDR_CAL:    next_st.rdata = {8'h00, st.cal};
            `CSC_ADDR_FUSE:   next_st.rdata = {9'h000, st.fuse};
            default:          next_st.rdata = 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // State register, shipped configuration as reset value
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         st.state <= ST_RESET;
         st.mode  <= SLP_IDLE;
         st.fuse  <= {`CSC_SHIP_AMP, `CSC_SHIP_STARTUP, `CSC_SHIP_SOURCE};
         st.count <= 17'h00000;
         st.cal   <= `CSC_CAL_RESET;
         st.en    <= '0;
         st.detect <= 1'b0;
         st.rdata <= 16'h0000;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign rdata                   = st.rdata;
   assign core_clock_en           = st.en.core;
   assign peripheral_clock_en     = st.en.periph;
   assign program_memory_clock_en = st.en.flash;
   assign async_timer_clock_en    = st.en.asy;
   assign converter_clock_en      = st.en.conv;
   assign async_detect_en         = st.detect;
   assign rc_calibration_register = st.cal;
   assign core_running            = st.en.core;

   // ==========================================================
   // Checks
   flash_follows_core_a: assert property (@(posedge ref_clk) disable iff (reset)
      program_memory_clock_en == core_clock_en)
      else $error("program memory clock differs from core clock");

   sleep_core_halt_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_SLEEP |-> !core_clock_en && !program_memory_clock_en)
      else $error("core clock running in sleep");

   detect_on_halt_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state != ST_RESET && !peripheral_clock_en |-> async_detect_en)
      else $error("async detection off while peripheral clock halted");

   psave_async_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_SLEEP && st.mode == SLP_PSAVE |-> async_timer_clock_en)
      else $error("async timer clock stopped in power-save");

   adc_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_SLEEP && st.mode == SLP_ADC_NR |-> converter_clock_en && !peripheral_clock_en)
      else $error("converter clock domain wrong in noise reduction");

   fuse_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state != ST_RESET && $past(st.state) != ST_RESET |-> $stable(st.fuse))
      else $error("configuration changed during operation");

   cal_load_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_RESET |=> rc_calibration_register == $past(cfg_q[7:0]))
      else $error("calibration not loaded after reset");

   wake_count_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_WAKE && !start_done |=> !core_clock_en)
      else $error("core started before wake count finished");

   delay_wdt_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_RST_DELAY && !wdt_tick |=> $stable(st.count))
      else $error("reset delay counted without watchdog tick");

   restart_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(st.state == ST_WAKE) |-> st.count == 17'h00000)
      else $error("wake count did not restart at zero");

   // ==========================================================
   // Domain gating checks
   run_all_on_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_RUN |-> core_clock_en && peripheral_clock_en && async_timer_clock_en && converter_clock_en)
      else $error("clock domain off while running");

   run_no_detect_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_RUN |-> !async_detect_en)
      else $error("async detection on while running");

   idle_domains_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_SLEEP && st.mode == SLP_IDLE |-> peripheral_clock_en && converter_clock_en)
      else $error("idle sleep stopped a peripheral domain");

   pdown_all_off_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_SLEEP && st.mode == SLP_PDOWN |-> !async_timer_clock_en && !converter_clock_en)
      else $error("clock running in power-down");

   start_async_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_OSC_START && st.mode != SLP_PDOWN |-> async_timer_clock_en)
      else $error("async timer clock stopped during start-up");

   // ==========================================================
   // Start-up sequencer checks
   start_core_off_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_OSC_START || st.state == ST_RST_DELAY |-> !core_clock_en)
      else $error("core clock before start-up finished");

   reset_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_RESET |=> st.state == ST_OSC_START && st.count == 17'h00000)
      else $error("start-up count did not begin at zero");

   osc_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_OSC_START && !src_tick |=> st.state == ST_OSC_START && $stable(st.count))
      else $error("start-up count moved without a source tick");

   delay_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_RST_DELAY && !wdt_tick |=> st.state == ST_RST_DELAY)
      else $error("reset delay ended without a watchdog tick");

   delay_bound_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.state == ST_RST_DELAY |-> st.count < LONG_TIMEOUT_CYCLES)
      else $error("reset delay count beyond long time-out");

endmodule : csc_clock_control

//--- testbench/csc_osc_model.sv
`timescale 1ns/1ns
// ==========================================================
// Oscillator model: emits a budget of ticks, the line stands low when stopped
module csc_osc_model
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  half,
   input  wire logic [17:0] src_budget,
   input  wire logic [17:0] wd_budget,
   output logic             source_tick,
   output logic             watchdog_tick,
   output logic [17:0]      src_count,
   output logic [17:0]      wd_count
);
   logic [7:0] src_ph;
   logic [7:0] wd_ph;

   // Each line toggles every half cycles; a started tick always completes low
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         {source_tick, watchdog_tick, src_count, wd_count, src_ph, wd_ph} <= '0;
      end
      else
      begin
         if (source_tick || src_count < src_budget)
         begin
            src_ph <= (src_ph + 8'h01 >= half) ? 8'h00 : src_ph + 8'h01;
            if (src_ph + 8'h01 >= half)
            begin
               source_tick <= !source_tick;
               src_count   <= source_tick ? src_count : src_count + 18'h00001;
            end
         end
         if (watchdog_tick || wd_count < wd_budget)
         begin
            wd_ph <= (wd_ph + 8'h01 >= half) ? 8'h00 : wd_ph + 8'h01;
            if (wd_ph + 8'h01 >= half)
            begin
               watchdog_tick <= !watchdog_tick;
               wd_count      <= watchdog_tick ? wd_count : wd_count + 18'h00001;
            end
         end
      end
   end
endmodule : csc_osc_model

//--- testbench/csc_clock_control_tb_top.sv
`timescale 1ns/1ns
`include "csc_defs.svh"
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin err_total++; \
   $display("Error at %0t: got %0h expected %0h", $time, (act), (exp)); end end
// ==========================================================
// Bench for the clock source and start-up controller
module clock_source_startup_control_tb_top;
   import csc_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  clock_source_select = 4'h1;
   logic [1:0]  startup_time_select = 2'h2;
   logic        oscillator_amp_option = 1'b1;
   logic [7:0]  factory_calibration = 8'h00;
   logic        wake_event = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic [7:0]  half = 8'h02;
   logic [17:0] src_budget = 18'h00000;
   logic [17:0] wd_budget = 18'h00000;
   logic        source_tick, watchdog_tick, core_running, async_detect_en;
   logic        core_clock_en, peripheral_clock_en, program_memory_clock_en;
   logic        async_timer_clock_en, converter_clock_en;
   logic [17:0] src_count, wd_count;
   logic [15:0] rdata;
   logic [15:0] d;
   logic [7:0]  rc_calibration_register;
   int          err_total = 0;
   int          checks = 0;
   int          cycles = 0;

   csc_clock_control #(.SHORT_TIMEOUT_CYCLES(17'h00008), .LONG_TIMEOUT_CYCLES(17'h00010),
                       .CNT_16K(17'h00014), .CNT_32K(17'h00018)) DUT
   (
      .ref_clk(ref_clk), .reset(reset), .clock_source_select(clock_source_select),
      .startup_time_select(startup_time_select), .oscillator_amp_option(oscillator_amp_option),
      .factory_calibration(factory_calibration), .source_tick(source_tick),
      .watchdog_tick(watchdog_tick), .wake_event(wake_event), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .core_clock_en(core_clock_en),
      .peripheral_clock_en(peripheral_clock_en), .program_memory_clock_en(program_memory_clock_en),
      .async_timer_clock_en(async_timer_clock_en), .converter_clock_en(converter_clock_en),
      .async_detect_en(async_detect_en), .rc_calibration_register(rc_calibration_register),
      .core_running(core_running)
   );

   csc_osc_model OSC
   (
      .ref_clk(ref_clk), .reset(reset), .half(half), .src_budget(src_budget),
      .wd_budget(wd_budget), .source_tick(source_tick), .watchdog_tick(watchdog_tick),
      .src_count(src_count), .wd_count(wd_count)
   );

   // Clock at 250 MHz
   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_total++;
         summarize();
      end
   end

   task summarize();
      $display("Comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   task wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge ref_clk);
      addr   <= a;
      wdata  <= w;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a);
      @(posedge ref_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // Lets n more ticks out of one oscillator, then waits out the sync delay
   task tick(input logic wd, input logic [17:0] n);
      int i;
      if (wd)
         wd_budget <= wd_budget + n;
      else
         src_budget <= src_budget + n;
      @(posedge ref_clk);
      for (i = 0; i < 20000 && (wd ? (wd_count !== wd_budget || watchdog_tick)
                                   : (src_count !== src_budget || source_tick)); i++)
         @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
   endtask : tick

   // Reset with one fuse setting and walk the start-up sequence
   task boot(input logic [3:0] s, input logic [1:0] t, input logic a, input logic [17:0] ns,
             input logic [17:0] nw, input logic [2:0] k, input logic [2:0] r, input logic [3:0] m);
      reset                 <= 1'b1;
      src_budget            <= 18'h00000;
      wd_budget             <= 18'h00000;
      clock_source_select   <= s;
      startup_time_select   <= t;
      oscillator_amp_option <= a;
      factory_calibration   <= {4'hA, s};
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`CSC_ADDR_FUSE);
      `CHK(d, {9'h000, a, t, s})
      `CHK(rc_calibration_register, {4'hA, s})
      rd(`CSC_ADDR_STATUS);
      `CHK(d[9:7], k)
      `CHK(d[6:4], r)
      if (k == 3'h1) `CHK(d[3:0], m)
      tick(1'b0, ns - 18'h00001);
      rd(`CSC_ADDR_STATUS);
      `CHK(d[15:10], 6'h02)
      tick(1'b0, 18'h00001);
      rd(`CSC_ADDR_STATUS);
      `CHK(d[15:10], (nw == 18'h0) ? 6'h08 : 6'h04)
      if (nw != 18'h0)
      begin
         tick(1'b1, nw - 18'h00001);
         rd(`CSC_ADDR_STATUS);
         `CHK(d[15:10], 6'h04)
         tick(1'b1, 18'h00001);
         rd(`CSC_ADDR_STATUS);
         `CHK(d[15:10], 6'h08)
      end
      `CHK(core_running, 1'b1)
      $display("Boot test done: source %0h start-up %0h", s, t);
   endtask : boot

   // Enter one sleep mode, check the domain enables, then wake
   task nap(input logic [1:0] mode, input logic [4:0] e, input logic deep, input logic [17:0] ns);
      wr(`CSC_ADDR_CTRL, {14'h0000, mode} | 16'h0004);
      repeat (2) @(posedge ref_clk);
      `CHK({core_clock_en, peripheral_clock_en, program_memory_clock_en, async_timer_clock_en,
            converter_clock_en}, e)
      `CHK(async_detect_en, !e[3])
      rd(`CSC_ADDR_CTRL);
      `CHK(d, {14'h0000, mode})
      wake_event <= 1'b1;
      repeat (6) @(posedge ref_clk);
      wake_event <= 1'b0;
      if (deep)
      begin
         tick(1'b0, ns - 18'h00001);
         rd(`CSC_ADDR_STATUS);
         `CHK(d[15:10], 6'h20)
         tick(1'b0, 18'h00001);
      end
      rd(`CSC_ADDR_STATUS);
      `CHK(d[15:10], 6'h08)
      `CHK(core_running, 1'b1)
      $display("Sleep test done: mode %0h", mode);
   endtask : nap

   // Main sequence
   initial
   begin
      boot(4'h1, 2'h2, 1'b1, 18'd6, 18'd16, 3'h1, 3'h0, 4'h1);
      boot(4'h4, 2'h0, 1'b1, 18'd6, 18'd0, 3'h1, 3'h0, 4'h8);
      boot(4'h0, 2'h1, 1'b0, 18'd6, 18'd8, 3'h0, 3'h0, 4'h0);
      boot(4'h5, 2'h3, 1'b1, 18'd6, 18'd8, 3'h2, 3'h0, 4'h0);
      boot(4'h8, 2'h0, 1'b1, 18'd18, 18'd0, 3'h2, 3'h0, 4'h0);
      boot(4'h9, 2'h0, 1'b1, 18'd1024, 18'd8, 3'h3, 3'h0, 4'h0);
      half <= 8'h06;
      boot(4'h9, 2'h2, 1'b1, 18'd24, 18'd16, 3'h3, 3'h0, 4'h0);
      half <= 8'h02;
      boot(4'hA, 2'h0, 1'b1, 18'd258, 18'd8, 3'h4, 3'h1, 4'h0);
      boot(4'hC, 2'h1, 1'b1, 18'd258, 18'd16, 3'h4, 3'h2, 4'h0);
      boot(4'hE, 2'h2, 1'b1, 18'd1024, 18'd0, 3'h4, 3'h3, 4'h0);
      boot(4'hA, 2'h3, 1'b0, 18'd1024, 18'd8, 3'h4, 3'h4, 4'h0);
      boot(4'hB, 2'h0, 1'b1, 18'd1024, 18'd16, 3'h4, 3'h1, 4'h0);
      boot(4'hD, 2'h1, 1'b1, 18'd20, 18'd0, 3'h4, 3'h2, 4'h0);
      boot(4'hF, 2'h2, 1'b0, 18'd20, 18'd8, 3'h4, 3'h4, 4'h0);
      boot(4'hF, 2'h3, 1'b1, 18'd20, 18'd16, 3'h4, 3'h3, 4'h0);
      nap(2'h0, 5'b01011, 1'b0, 18'd20);
      nap(2'h1, 5'b00011, 1'b0, 18'd20);
      nap(2'h2, 5'b00000, 1'b1, 18'd20);
      nap(2'h3, 5'b00010, 1'b1, 18'd20);
      // Register odds and ends: calibration, read-only and unmapped places
      wr(`CSC_ADDR_CAL, 16'h005A);
      rd(`CSC_ADDR_CAL);
      `CHK(d, 16'h005A)
      `CHK(rc_calibration_register, 8'h5A)
      clock_source_select <= 4'h2;
      wr(`CSC_ADDR_FUSE, 16'h0000);
      wr(`CSC_ADDR_STATUS, 16'hFFFF);
      wr(4'hF, 16'hFFFF);
      rd(`CSC_ADDR_FUSE);
      `CHK(d, 16'h007F)
      rd(4'hF);
      `CHK(d, 16'h0000)
      rd(`CSC_ADDR_STATUS);
      `CHK(d[15:7], {6'h08, 3'h4})
      $display("Register test done");
      summarize();
   end
endmodule : clock_source_startup_control_tb_top
